// file: spi_byte_shifter_ctrl.sv
/*
  Holds the byte-wide serial shifter: CPU registers, transmit queue and the link-side engine.
  Assumes a register port on clk_i and a free-running link clock; it drives the serial clock.
*/
// How it works
// - Control bit seven picks LSB-first order
// - Overrun sets on unread reload, read clears
// - Complete sets after last clock, read clears
// - Transmit empty reads one after reset, disabled
// - Tx write clears empty, buffer free sets
// - Empty output fires only after first move
// - Receive full sets on load, rx read clears
// - Phase bit picks sampling or changing edge
// - Polarity bit sets serial clock idle level
// - Mode number from phase and polarity bits
// - Enable bit runs function; off sets transmit empty, holds other flags
// - Write-only transmit data register at 0x29
// - Read-only receive data register at 0x2A
`timescale 1ns/10ps
`default_nettype none
`include "spi_shift_params.svh"

module spi_byte_shifter_ctrl
  import spi_shift_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       clk_en_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            tx_empty_irq_o,
  input  wire logic       link_clk_i,
  output logic            sclk_o,
  output logic            mosi_o,
  input  wire logic       miso_i
);

  function automatic logic out_bit(input byte_t d, input logic lsb);
    return lsb ? d[0] : d[`BYTE_W-1];
  endfunction
  function automatic byte_t shift_out(input byte_t d, input logic lsb);
    return lsb ? (d >> 1) : (d << 1);
  endfunction
  function automatic byte_t shift_in(input byte_t d, input logic b, input logic lsb);
    return lsb ? {b, d[`BYTE_W-1:1]} : {d[`BYTE_W-2:0], b};
  endfunction

  // ------------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------------
  logic  lsb_reg, cpha_reg, cpol_reg, en_reg;
  logic  ovr_reg, cmpl_reg, txe_reg, rxf_reg, arm_reg, busy_reg, req_tog_reg;
  logic  done_s1, done_s2, done_s3, done_tog_reg;
  byte_t tx_buf_reg, rx_buf_reg, tx_word_reg, rdata_reg;
  byte_t rx_word_reg;
  byte_t status_word, read_mux, fifo_out_data;
  logic  fifo_in_ready, fifo_out_valid;

  wire wr_tx   = wr_i && (addr_i == `ADDR_TX_BUF);
  wire wr_ctrl = wr_i && (addr_i == `ADDR_CTRL);
  wire rd_rx   = rd_i && (addr_i == `ADDR_RX_BUF);
  wire rd_ctrl = rd_i && (addr_i == `ADDR_CTRL);
  wire en_next = wr_ctrl ? wdata_i[`BIT_ENABLE] : en_reg;
  wire tx_take = wr_tx && en_reg;
  wire push    = en_reg && !txe_reg && fifo_in_ready;
  wire start   = en_reg && !busy_reg && fifo_out_valid;
  wire done_evt = done_s2 ^ done_s3;
  assign status_word[`BIT_LSB_FIRST] = lsb_reg;
  assign status_word[`BIT_OVERRUN]   = ovr_reg;
  assign status_word[`BIT_COMPLETE]  = cmpl_reg;
  assign status_word[`BIT_TX_EMPTY]  = txe_reg;
  assign status_word[`BIT_RX_FULL]   = rxf_reg;
  assign status_word[`BIT_CPHA]      = cpha_reg;
  assign status_word[`BIT_CPOL]      = cpol_reg;
  assign status_word[`BIT_ENABLE]    = en_reg;
  // Transmit buffer reads back as zero; it is write-only
  assign read_mux = rd_ctrl ? status_word :
                    rd_rx   ? rx_buf_reg  : `BYTE_RESET;

  // ------------------------------------------------------------------
  // Status next values; a hardware set wins over a read clear; a transmit write or a disable wins over a set
  // ------------------------------------------------------------------
  wire txe_next  = !en_next ? `TX_EMPTY_RESET :
                   tx_take  ? 1'b0 : push ? 1'b1 : txe_reg;
  wire ovr_next  = (done_evt && rxf_reg && !rd_rx) ? 1'b1 :
                   rd_ctrl ? 1'b0 : ovr_reg;
  wire cmpl_next = done_evt ? 1'b1 : rd_ctrl ? 1'b0 : cmpl_reg;
  wire rxf_next  = done_evt ? 1'b1 : rd_rx ? 1'b0 : rxf_reg;
  wire arm_next  = !en_next ? 1'b0 : push ? 1'b1 : arm_reg;
  assign rdata_o        = rdata_reg;
  assign tx_empty_irq_o = arm_reg && txe_reg;

  // ------------------------------------------------------------------
  // Transmit queue between buffer and shifter
  // ------------------------------------------------------------------
  byte_fifo #(
    .WIDTH (`BYTE_W),
    .DEPTH (`FIFO_DEPTH)
  ) tx_queue (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .clk_en_i    (clk_en_i),
    .flush_i     (!en_reg),
    .in_valid_i  (en_reg && !txe_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (tx_buf_reg),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (start),
    .out_data_o  (fifo_out_data)
  );

  // ------------------------------------------------------------------
  // CPU-side registers
  // ------------------------------------------------------------------
  // Mode bits are taken on any control write; software keeps them fixed while enabled
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      {lsb_reg, cpha_reg, cpol_reg, en_reg} <= '0;
      {ovr_reg, cmpl_reg, rxf_reg, arm_reg} <= '0;
      txe_reg    <= `TX_EMPTY_RESET;
      tx_buf_reg <= `BYTE_RESET;
      rx_buf_reg <= `BYTE_RESET;
      rdata_reg  <= `BYTE_RESET;
    end
    else if (clk_en_i)
    begin
      if (wr_ctrl)
      begin
        lsb_reg  <= wdata_i[`BIT_LSB_FIRST];
        cpha_reg <= wdata_i[`BIT_CPHA];
        cpol_reg <= wdata_i[`BIT_CPOL];
      end
      en_reg  <= en_next;
      txe_reg <= txe_next;
      ovr_reg <= ovr_next;
      cmpl_reg <= cmpl_next;
      rxf_reg <= rxf_next;
      arm_reg <= arm_next;
      if (tx_take)
        tx_buf_reg <= wdata_i;
      if (done_evt)
        rx_buf_reg <= rx_word_reg;
      if (rd_i)
        rdata_reg <= read_mux;
    end
  end

  // Word stays still while a request is open, so the link reads it directly; mode bits pass through synchronisers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      busy_reg    <= 1'b0;
      req_tog_reg <= 1'b0;
      tx_word_reg <= `BYTE_RESET;
      {done_s1, done_s2, done_s3} <= '0;
    end
    else if (clk_en_i)
    begin
      {done_s1, done_s2, done_s3} <= {done_tog_reg, done_s1, done_s2};
      if (start)
      begin
        busy_reg    <= 1'b1;
        req_tog_reg <= ~req_tog_reg;
        tx_word_reg <= fifo_out_data;
      end
      else if (done_evt)
        busy_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Link domain: synchronisers
  // ------------------------------------------------------------------
  logic        lrst_s1, link_rst;
  logic        req_s1, req_s2, req_s3;
  logic  [2:0] cfg_s1, cfg_s2;
  logic        miso_s1, miso_s2;
  link_state_t state_reg;
  logic  [3:0] div_reg, edge_reg;
  logic  [4:0] tog_cnt_reg;
  logic        sclk_reg, mosi_reg;
  byte_t       sh_tx_reg, sh_rx_reg;
  always_ff @(posedge link_clk_i)
  begin
    lrst_s1  <= reset_i;
    link_rst <= lrst_s1;
    req_s1   <= req_tog_reg;
    req_s2   <= req_s1;
    req_s3   <= req_s2;
    cfg_s1   <= {lsb_reg, cpha_reg, cpol_reg};
    cfg_s2   <= cfg_s1;
    miso_s1  <= miso_i;
    miso_s2  <= miso_s1;
  end
  // Mode number is twice phase plus polarity: 1 and 3 idle high, 2 and 3 lead-change
  wire lsb_s     = cfg_s2[2];
  wire cpha_s    = cfg_s2[1];
  wire cpol_s    = cfg_s2[0];
  wire req_evt   = req_s2 ^ req_s3;
  wire tick      = (div_reg == `HALF_BIT_LAST);
  wire leading   = !edge_reg[0];
  wire sample_now = leading ^ cpha_s;
  assign sclk_o = sclk_reg;
  assign mosi_o = mosi_reg;

  // ------------------------------------------------------------------
  // Link domain: shift engine
  // ------------------------------------------------------------------
  // Half bit spans four link cycles so the synchronised input has settled at each sample
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      state_reg <= LINK_IDLE;
      {div_reg, edge_reg, tog_cnt_reg} <= '0;
      {sclk_reg, mosi_reg, done_tog_reg} <= '0;
      sh_tx_reg   <= `BYTE_RESET;
      sh_rx_reg   <= `BYTE_RESET;
      rx_word_reg <= `BYTE_RESET;
    end
    else
    begin
      case (state_reg)
        LINK_IDLE:
        begin
          sclk_reg <= cpol_s;
          {div_reg, edge_reg, tog_cnt_reg} <= '0;
          if (req_evt)
          begin
            state_reg <= LINK_RUN;
            if (!cpha_s)
            begin
              mosi_reg  <= out_bit(tx_word_reg, lsb_s);
              sh_tx_reg <= shift_out(tx_word_reg, lsb_s);
            end
            else
              sh_tx_reg <= tx_word_reg;
          end
        end
        LINK_RUN:
        begin
          div_reg <= tick ? '0 : div_reg + 1'b1;
          if (tick)
          begin
            sclk_reg    <= ~sclk_reg;
            edge_reg    <= edge_reg + 1'b1;
            tog_cnt_reg <= tog_cnt_reg + 1'b1;
            if (sample_now)
              sh_rx_reg <= shift_in(sh_rx_reg, miso_s2, lsb_s);
            else if (edge_reg != `LAST_EDGE)
            begin
              mosi_reg  <= out_bit(sh_tx_reg, lsb_s);
              sh_tx_reg <= shift_out(sh_tx_reg, lsb_s);
            end
            if (edge_reg == `LAST_EDGE)
              state_reg <= LINK_DONE;
          end
        end
        LINK_DONE:
        begin
          rx_word_reg  <= sh_rx_reg;
          done_tog_reg <= ~done_tog_reg;
          state_reg    <= LINK_IDLE;
        end
        default:
          state_reg <= LINK_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence start_s;
    clk_en_i && start;
  endsequence
  sequence done_s;
    done_evt;
  endsequence
  property xfer_p;
    @(posedge clk_i) disable iff (reset_i || !clk_en_i)
    start_s |=> busy_reg ##[1:1000] done_s;
  endproperty
  xfer_runs_a: assert property (xfer_p)
    else $error("queued byte did not complete a transfer");
  txe_disabled_a: assert property (
    @(posedge clk_i) disable iff (reset_i) (clk_en_i && !en_next) |=> txe_reg)
    else $error("transmit empty low while disabled");
  txe_write_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (clk_en_i && tx_take && en_next) |=> !txe_reg && tx_buf_reg == $past(wdata_i))
    else $error("transmit write did not fill buffer");
  irq_arm_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (clk_en_i && push && en_next && !tx_take) |=> tx_empty_irq_o)
    else $error("empty output missing after byte moved");
  rxf_load_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (clk_en_i && done_evt) |=> rxf_reg && rx_buf_reg == rx_word_reg)
    else $error("receive buffer not loaded");
  ovr_set_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (clk_en_i && done_evt && rxf_reg && !rd_rx) |=> ovr_reg)
    else $error("overrun not flagged");
  cmpl_clear_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (clk_en_i && rd_ctrl && !done_evt) |=> !cmpl_reg && !ovr_reg)
    else $error("control read did not clear flags");
  first_bit_a: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    (state_reg == LINK_IDLE && req_evt && !cpha_s)
      |=> mosi_reg == out_bit(tx_word_reg, lsb_s))
    else $error("wrong first data bit");
  lead_hold_a: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    (state_reg == LINK_RUN && tick && leading && !cpha_s) |=> $stable(mosi_reg))
    else $error("data changed on sampling edge");
  idle_level_a: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    (state_reg == LINK_DONE) |-> sclk_reg == cpol_s)
    else $error("serial clock not at idle level");
  edge_count_a: assert property (
    @(posedge link_clk_i) disable iff (link_rst)
    (state_reg == LINK_DONE) |-> tog_cnt_reg == `EDGES_PER_BYTE)
    else $error("transfer did not make sixteen clock edges");

endmodule // spi_byte_shifter_ctrl

`default_nettype wire

// file: spi_shift_params.svh
/*
  Holds the register offsets, status and control bit positions, reset values and link timing
  counts of the byte shifter.
  Assumes it is included by its bare name from the design files.
*/
`ifndef SPI_SHIFT_PARAMS_SVH
`define SPI_SHIFT_PARAMS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define ADDR_TX_BUF      8'h29
`define ADDR_RX_BUF      8'h2A
`define ADDR_CTRL        8'h2B

// ------------------------------------------------------------------
// Control and status bit positions
// ------------------------------------------------------------------
`define BIT_LSB_FIRST    7
`define BIT_OVERRUN      6
`define BIT_COMPLETE     5
`define BIT_TX_EMPTY     4
`define BIT_RX_FULL      3
`define BIT_CPHA         2
`define BIT_CPOL         1
`define BIT_ENABLE       0

// ------------------------------------------------------------------
// Sizes, reset values and link timing
// ------------------------------------------------------------------
`define BYTE_W           8
`define FIFO_DEPTH       4
`define BYTE_RESET       8'h00
`define TX_EMPTY_RESET   1'b1
`define HALF_BIT_LAST    4'h3
`define LAST_EDGE        4'hF
`define EDGES_PER_BYTE   5'h10

`endif

// file: spi_shift_pkg.sv
/*
  Holds the types shared by the byte shifter files.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package spi_shift_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {LINK_IDLE, LINK_RUN, LINK_DONE} link_state_t;
endpackage

`default_nettype wire

// file: byte_fifo.sv
/*
  Holds a small synchronous FIFO with valid and ready on both sides and a flush input.
  Assumes one clock, a synchronous active-high reset and a clock enable from the parent.
*/
`timescale 1ns/10ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             clk_en_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push;
  wire              pop;

  function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
    return (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  // ------------------------------------------------------------------
  // Flags and handshakes
  // ------------------------------------------------------------------
  assign in_ready_o  = (count_reg != CNT_FULL);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (clk_en_i && push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || (clk_en_i && flush_i))
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (clk_en_i)
    begin
      if (push)
        wr_ptr_reg <= ptr_step(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= ptr_step(rd_ptr_reg);
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule // byte_fifo

`default_nettype wire

// file: spi_peer_model.sv
/*
  Holds a behavioural serial peer that shifts a reply byte out on miso and collects the mosi byte.
  Assumes the bench gives it the mode bits and holds en_i low while the serial clock idle level moves.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_peer_model (
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_first_i,
  input  wire logic       en_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic      [7:0] got_o
);
  logic [7:0] in_sr;
  int         nbits;
  logic       leading;

  // ------------------------------------------------------------------
  // Bit order and preload
  // ------------------------------------------------------------------
  function automatic int pos(input int n);
    return lsb_first_i ? n : 7 - n;
  endfunction

  initial
  begin
    miso_o = 1'b0;
    got_o = 8'h00;
    in_sr = 8'h00;
    nbits = 0;
  end

  // Phase 0 needs the first bit before the first leading edge
  always @(reply_i or en_i or cpha_i or lsb_first_i)
    if (nbits == 0 && !cpha_i)
      miso_o = reply_i[pos(0)];

  // ------------------------------------------------------------------
  // Edge handling
  // ------------------------------------------------------------------
  // No chip select exists, so a stray idle-level move would look like an edge
  always @(sclk_i)
  begin
    leading = (sclk_i != cpol_i);
    if (!en_i)
      nbits = 0;
    else if (leading != cpha_i)
    begin
      in_sr[pos(nbits)] = mosi_i;
      nbits = nbits + 1;
      if (nbits == 8)
      begin
        got_o = in_sr;
        nbits = 0;
      end
    end
    else
      miso_o = reply_i[pos(nbits)];
  end
endmodule // spi_peer_model

`default_nettype wire

// file: testbench.sv
/*
  Holds the self-checking bench for the byte shifter: register tasks, mode loop, queue and overrun.
  Assumes the design files and the serial peer model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spi_shift_params.svh"

module testbench
  import spi_shift_pkg::*;
;
  logic  clk;
  logic  reset;
  logic  clk_en;
  byte_t addr;
  byte_t wdata;
  logic  wr;
  logic  rd;
  byte_t rdata;
  logic  irq;
  logic  link_clk;
  logic  sclk;
  logic  mosi;
  logic  miso;
  logic  p_cpol;
  logic  p_cpha;
  logic  p_lsb;
  logic  p_en;
  byte_t reply;
  byte_t got;
  byte_t s;
  byte_t cfg;
  byte_t txb;
  int    mismatches;
  int    cmp_count;

  // ------------------------------------------------------------------
  // Clocks, design and peer
  // ------------------------------------------------------------------
  always #4 clk = ~clk;

  // Odd offset keeps link edges clear of system edges
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #32 link_clk = ~link_clk;
  end

  spi_byte_shifter_ctrl dut (
    .clk_i(clk), .reset_i(reset), .clk_en_i(clk_en), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_empty_irq_o(irq), .link_clk_i(link_clk),
    .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso)
  );

  spi_peer_model peer (
    .sclk_i(sclk), .mosi_i(mosi), .cpol_i(p_cpol), .cpha_i(p_cpha), .lsb_first_i(p_lsb),
    .en_i(p_en), .reply_i(reply), .miso_o(miso), .got_o(got)
  );

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check8(input byte_t g, input byte_t e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic reg_wr(input byte_t a, input byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input byte_t a, output byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic rd_check(input byte_t a, input byte_t e);
    byte_t d;
    reg_rd(a, d);
    check8(d, e);
  endtask

  // Polling clears complete, so the caller gets the read that saw it
  task automatic wait_complete(output byte_t d);
    for (int i = 0; i < 2000; i++)
    begin
      reg_rd(`ADDR_CTRL, d);
      if (d[`BIT_COMPLETE] === 1'b1)
        return;
    end
    mismatches++;
    conclude();
  endtask

  task automatic peer_setup(input byte_t c);
    p_en <= 1'b0;
    reg_wr(`ADDR_CTRL, c);
    repeat (40) @(posedge clk);
    p_lsb <= c[`BIT_LSB_FIRST];
    p_cpha <= c[`BIT_CPHA];
    p_cpol <= c[`BIT_CPOL];
    p_en <= 1'b1;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    p_cpol = 1'b0;
    p_cpha = 1'b0;
    p_lsb = 1'b0;
    p_en = 1'b0;
    reply = 8'h00;
    mismatches = 0;
    cmp_count = 0;
    // Longer than two cycles: the link reset needs three link edges
    repeat (26) @(posedge clk);
    reset <= 1'b0;
    rd_check(`ADDR_CTRL, 8'h10);
    rd_check(`ADDR_RX_BUF, 8'h00);
    rd_check(`ADDR_TX_BUF, 8'h00);
    rd_check(8'h30, 8'h00);
    check8({7'h00, irq}, 8'h00);
    check8({7'h00, sclk}, 8'h00);
    reg_wr(`ADDR_TX_BUF, 8'hAA);
    reg_wr(`ADDR_RX_BUF, 8'h55);
    rd_check(`ADDR_RX_BUF, 8'h00);
    rd_check(`ADDR_CTRL, 8'h10);
    // Clock enable low freezes the register port, so this write is lost
    @(posedge clk);
    clk_en <= 1'b0;
    reg_wr(`ADDR_CTRL, 8'hFF);
    clk_en <= 1'b1;
    rd_check(`ADDR_CTRL, 8'h10);
    reg_wr(`ADDR_CTRL, 8'hFF);
    rd_check(`ADDR_CTRL, 8'h97);
    reg_wr(`ADDR_CTRL, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      cfg = {m[1] ^ m[0], 4'h0, m[1], m[0], 1'b1};
      txb = 8'h1D + 8'h22 * m;
      reply <= 8'h4E ^ 8'h11 * m;
      peer_setup(cfg);
      check8({7'h00, sclk}, {7'h00, cfg[`BIT_CPOL]});
      rd_check(`ADDR_CTRL, cfg | 8'h10);
      check8({7'h00, irq}, 8'h00);
      reg_wr(`ADDR_TX_BUF, txb);
      wait_complete(s);
      check8(s, cfg | 8'h38);
      check8({7'h00, irq}, 8'h01);
      check8(got, txb);
      rd_check(`ADDR_CTRL, cfg | 8'h18);
      rd_check(`ADDR_RX_BUF, 8'h4E ^ 8'h11 * m);
      rd_check(`ADDR_CTRL, cfg | 8'h10);
      reg_wr(`ADDR_CTRL, cfg & 8'hFE);
      rd_check(`ADDR_CTRL, (cfg & 8'hFE) | 8'h10);
      check8({7'h00, irq}, 8'h00);
    end
    // Queue fill: buffer, four queued and one shifting
    reply <= 8'hB4;
    peer_setup(8'h01);
    for (int i = 0; i < 6; i++)
      reg_wr(`ADDR_TX_BUF, 8'h30 + i);
    reg_rd(`ADDR_CTRL, s);
    check8(s & 8'h10, 8'h00);
    wait_complete(s);
    check8(s & 8'h48, 8'h08);
    wait_complete(s);
    check8(s & 8'h68, 8'h68);
    check8(got, 8'h31);
    reg_rd(`ADDR_CTRL, s);
    check8(s & 8'h40, 8'h00);
    reg_wr(`ADDR_CTRL, 8'h00);
    reg_rd(`ADDR_CTRL, s);
    check8(s & 8'h11, 8'h10);
    reg_wr(`ADDR_TX_BUF, 8'hAA);
    repeat (1000) @(posedge clk);
    rd_check(`ADDR_RX_BUF, 8'hB4);
    reg_rd(`ADDR_CTRL, s);
    check8(s & 8'h19, 8'h10);
    conclude();
  end
endmodule // testbench

`default_nettype wire
